// ===== include/icm_pkg.sv
// constants, states and limit tables for the indicator configuration menu
// assumes one 25 MHz clock and a 1 ms tick derived from it
package icm_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int INACT_S = 60;
    localparam int INACT_TICKS = INACT_S * 1_000_000 / TICK_US;
    localparam int HOLD_MS = 1000;
    localparam int ENTRY_MS = 2000;
    localparam int FAST_MS = 2000;
    localparam int REP_SLOW_MS = 200;
    localparam int REP_FAST_MS = 40;
    localparam int SAMPLE_MS = 10;
    localparam int HOLD_TICKS = HOLD_MS * 1000 / TICK_US;
    localparam int ENTRY_TICKS = ENTRY_MS * 1000 / TICK_US;
    localparam int FAST_TICKS = FAST_MS * 1000 / TICK_US;
    localparam int REP_SLOW_TICKS = REP_SLOW_MS * 1000 / TICK_US;
    localparam int REP_FAST_TICKS = REP_FAST_MS * 1000 / TICK_US;
    localparam int SAMPLE_TICKS = SAMPLE_MS * 1000 / TICK_US;
    // parameter slots
    localparam int NPARAM = 7;
    localparam int P_TYPE = 0;
    localparam int P_SENS = 1;
    localparam int P_DP = 2;
    localparam int P_DLO = 3;
    localparam int P_DHI = 4;
    localparam int P_LIM = 5;
    localparam int P_FILTER_TIME_MENU = 6;
    localparam logic [2:0] P_NONE = 3'h7;
    // input types
    localparam logic [15:0] VOLTAGE_INPUT_TYPE = 16'h0000;
    localparam logic [15:0] CURRENT_INPUT_TYPE = 16'h0001;
    localparam logic [15:0] RTD_INPUT_TYPE = 16'h0002;
    localparam logic [15:0] THERMOCOUPLE_INPUT_TYPE = 16'h0003;
    localparam logic [15:0] FREQUENCY_INPUT_TYPE = 16'h0004;
    localparam logic [15:0] ROTATION_INPUT_TYPE = 16'h0005;
    localparam logic [15:0] COUNT_UP_INPUT_TYPE = 16'h0006;
    localparam logic [15:0] COUNT_DOWN_INPUT_TYPE = 16'h0007;
    localparam logic [15:0] SERIAL_INTERFACE_TYPE = 16'h0008;
    // range limit modes
    localparam logic [15:0] LIMIT_OFF_MODE = 16'h0000;
    localparam logic [15:0] LIMIT_ERROR_MODE = 16'h0001;
    localparam logic [15:0] LIMIT_CLAMP_MODE = 16'h0002;
    // value ranges
    localparam logic [15:0] SENS_MAX_VOLT = 16'h0003;
    localparam logic [15:0] SENS_MAX_CURR = 16'h0001;
    localparam logic [15:0] DP_MAX = 16'h0003;
    localparam logic [15:0] DISP_MIN = 16'hF831;
    localparam logic [15:0] DISP_MAX = 16'h270F;
    localparam logic [15:0] FILTER_TIME_MENU_MIN = 16'h0001;
    localparam logic [15:0] FILTER_TIME_MENU_MAX = 16'h00C8;
    // measurement span in 1/10000 of selected range, margin 10 %
    localparam int SPAN_FULL = 10000;
    localparam int MARGIN = 1000;
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_HIGH = 2'h1;
    localparam logic [1:0] ERR_LOW = 2'h2;
    // factory defaults per slot
    localparam logic [15:0] DEF_VAL [NPARAM] = '{16'h0000, 16'h0000, 16'h0002,
        16'h0000, 16'h03E8, 16'h0000, 16'h000A};
    // register byte offsets
    localparam logic [7:0] REG_MEAS = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [7:0] REG_SCALE = 8'h0C;
    localparam logic [7:0] REG_FILTER_TIME_MENU = 8'h10;
    localparam logic [7:0] REG_DISP = 8'h14;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_INP = 9'h002,
        ST_SENS = 9'h004,
        ST_DP = 9'h008,
        ST_DLO = 9'h010,
        ST_DHI = 9'h020,
        ST_LIM = 9'h040,
        ST_FILTER_TIME_MENU = 9'h080,
        ST_OUTPUT_CONFIG_MENU = 9'h100
    } icm_state_t;
    // lower limit of each slot
    function automatic logic [15:0] icm_lo(input int idx);
        if (idx == P_DLO || idx == P_DHI)
            return DISP_MIN;
        if (idx == P_FILTER_TIME_MENU)
            return FILTER_TIME_MENU_MIN;
        return 16'h0000;
    endfunction
    // upper limit of each slot, sensor range depends on type
    function automatic logic [15:0] icm_hi(input int idx, input logic [15:0] typ);
        case (idx)
            P_TYPE: return SERIAL_INTERFACE_TYPE;
            P_SENS: return (typ == VOLTAGE_INPUT_TYPE) ? SENS_MAX_VOLT :
                (typ == CURRENT_INPUT_TYPE) ? SENS_MAX_CURR : 16'h0000;
            P_DP: return DP_MAX;
            P_LIM: return LIMIT_CLAMP_MODE;
            P_FILTER_TIME_MENU: return FILTER_TIME_MENU_MAX;
            default: return DISP_MAX;
        endcase
    endfunction
endpackage

// ===== logic/icm_top.sv
// three-button configuration menu with scaling, range limit and filter
// buttons are synchronous, active high; selftest_done_in high after segment test
`timescale 1ns/1ns
`default_nettype none
module icm_top
    import icm_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC,
    parameter int INACT_T_P = INACT_TICKS
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic btn_left_in,
    input wire logic btn_mid_in,
    input wire logic btn_right_in,
    input wire logic selftest_done_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rd_data_out,
    output logic [8:0] menu_out,
    output logic editing_out,
    output logic [15:0] edit_value_out,
    output logic in_config_out,
    output logic defaults_out,
    output logic [15:0] disp_value_out,
    output logic [1:0] disp_err_out,
    output logic [1:0] disp_dp_out
);
    localparam logic [15:0] HOLD_T = 16'(HOLD_TICKS);
    localparam logic [15:0] ENTRY_T = 16'(ENTRY_TICKS);
    localparam logic [15:0] FAST_T = 16'(HOLD_TICKS + FAST_TICKS);
    // by this hold count at least one fast repeat has fired
    localparam logic [15:0] FAST_SET_T = 16'(HOLD_TICKS + FAST_TICKS + REP_FAST_TICKS);
    localparam logic [15:0] SLOW_P = 16'(REP_SLOW_TICKS - 1);
    localparam logic [15:0] FAST_P = 16'(REP_FAST_TICKS - 1);
    localparam logic [15:0] INACT_T = 16'(INACT_T_P);
    localparam logic [15:0] TICK_T = 16'(TICK_CYC_P - 1);
    localparam logic [3:0] SAMP_T = 4'(SAMPLE_TICKS - 1);
    localparam logic signed [15:0] S_HI = 16'(SPAN_FULL);
    localparam logic signed [15:0] S_OVR = 16'(SPAN_FULL + MARGIN);
    localparam logic signed [15:0] S_UND = -16'(MARGIN);
    localparam logic signed [33:0] S_DIV = 34'(SPAN_FULL);

    icm_state_t state_r, state_nxt;
    logic edit_r, edit_nxt, need_rel_r, dflt_r;
    logic [2:0] btn_prev_r;
    logic [15:0] tick_cnt_r, hold_r, rep_r, idle_r;
    logic [3:0] samp_r;
    logic [15:0] sess_r [NPARAM];
    logic [15:0] cur_r [NPARAM];
    logic [15:0] sn_a [NPARAM];
    logic [15:0] lo_a [NPARAM];
    logic [15:0] hi_a [NPARAM];
    logic [15:0] up_a [NPARAM];
    logic [15:0] dn_a [NPARAM];
    logic [15:0] meas_r, filter_time_menu_y_r;

    // button edges, tick and timers
    wire lp = btn_left_in & ~btn_prev_r[0];
    wire mp = btn_mid_in & ~btn_prev_r[1];
    wire rp = btn_right_in & ~btn_prev_r[2];
    wire any_btn = btn_left_in | btn_mid_in | btn_right_in;
    wire tick = (tick_cnt_r == TICK_T);
    wire in_cfg = (state_r != ST_IDLE);
    wire held = btn_mid_in | btn_right_in;
    wire rep_fast = (hold_r >= FAST_T);
    wire [15:0] rep_per = rep_fast ? FAST_P : SLOW_P;
    wire rep_fire = tick & held & (hold_r >= HOLD_T) & (rep_r >= rep_per);
    wire abort = in_cfg & (idle_r >= INACT_T);
    wire entry = (state_r == ST_IDLE) & selftest_done_in & btn_mid_in
        & (hold_r >= ENTRY_T);

    // slot selected by the current menu label
    wire [2:0] sel_w = (state_r == ST_INP) ? 3'(P_TYPE) :
        (state_r == ST_SENS) ? 3'(P_SENS) :
        (state_r == ST_DP) ? 3'(P_DP) :
        (state_r == ST_DLO) ? 3'(P_DLO) :
        (state_r == ST_DHI) ? 3'(P_DHI) :
        (state_r == ST_LIM) ? 3'(P_LIM) :
        (state_r == ST_FILTER_TIME_MENU) ? 3'(P_FILTER_TIME_MENU) : P_NONE;

    // step requests, blocked until the entry hold is released
    wire ok_step = in_cfg & ~need_rel_r & ~lp & ~abort & (sel_w != P_NONE);
    wire step_up = ok_step & (mp | (rep_fire & btn_mid_in));
    wire step_dn = ok_step & ~step_up & (rp | (rep_fire & btn_right_in));
    wire stepped = step_up | step_dn;
    wire resets_later = stepped & (sel_w <= 3'(P_SENS));
    wire save = (state_r == ST_OUTPUT_CONFIG_MENU) & lp & ~abort;
    wire is_analog = (sess_r[P_TYPE] == VOLTAGE_INPUT_TYPE)
        | (sess_r[P_TYPE] == CURRENT_INPUT_TYPE);

    // per slot limits, wrap stepping and next value
    for (genvar i = 0; i < NPARAM; i++)
    begin : g_par
        assign lo_a[i] = icm_lo(i);
        assign hi_a[i] = icm_hi(i, sess_r[P_TYPE]);
        assign up_a[i] = ($signed(sess_r[i]) >= $signed(hi_a[i])) ? lo_a[i]
            : sess_r[i] + 16'h0001;
        assign dn_a[i] = ($signed(sess_r[i]) <= $signed(lo_a[i])) ? hi_a[i]
            : sess_r[i] - 16'h0001;
        assign sn_a[i] = entry ? cur_r[i] :
            (stepped && sel_w == 3'(i)) ? (step_up ? up_a[i] : dn_a[i]) :
            (resets_later && sel_w < 3'(i)) ? DEF_VAL[i] : sess_r[i];
        // session copy edited, committed copy kept until save
        always_ff @(posedge core_clk_in)
        begin
            if (!rst_n_in)
            begin
                sess_r[i] <= DEF_VAL[i];
                cur_r[i] <= DEF_VAL[i];
            end
            else if (ce_in)
            begin
                sess_r[i] <= sn_a[i];
                if (save)
                    cur_r[i] <= sess_r[i];
            end
        end
    end

    // menu walk; steps at a label open editing
    always_comb
    begin
        state_nxt = state_r;
        edit_nxt = edit_r;
        if (abort)
        begin
            state_nxt = ST_IDLE;
            edit_nxt = 1'b0;
        end
        else if (entry)
            state_nxt = ST_INP;
        else if (in_cfg && lp && edit_r)
            edit_nxt = 1'b0;
        else if (in_cfg && lp)
        begin
            unique case (state_r)
                ST_INP: state_nxt = is_analog ? ST_SENS : ST_OUTPUT_CONFIG_MENU;
                ST_SENS: state_nxt = ST_DP;
                ST_DP: state_nxt = ST_DLO;
                ST_DLO: state_nxt = ST_DHI;
                ST_DHI: state_nxt = ST_LIM;
                ST_LIM: state_nxt = ST_FILTER_TIME_MENU;
                ST_FILTER_TIME_MENU: state_nxt = ST_OUTPUT_CONFIG_MENU;
                ST_OUTPUT_CONFIG_MENU: state_nxt = ST_IDLE;
                ST_IDLE: state_nxt = ST_IDLE;
            endcase
        end
        else if (stepped)
            edit_nxt = 1'b1;
    end

    // state, buttons and entry-release latch
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_r <= ST_IDLE;
            edit_r <= 1'b0;
            need_rel_r <= 1'b0;
            btn_prev_r <= 3'h0;
            dflt_r <= 1'b0;
        end
        else if (ce_in)
        begin
            state_r <= state_nxt;
            edit_r <= edit_nxt;
            btn_prev_r <= {btn_right_in, btn_mid_in, btn_left_in};
            need_rel_r <= entry | (need_rel_r & btn_mid_in);
            dflt_r <= ~entry & (dflt_r | resets_later) & ~abort;
        end
    end

    // tick divider, hold, repeat and inactivity counters
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            tick_cnt_r <= 16'h0000;
            hold_r <= 16'h0000;
            rep_r <= 16'h0000;
            idle_r <= 16'h0000;
        end
        else if (ce_in)
        begin
            tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
            if (!held)
                hold_r <= 16'h0000;
            else if (tick && hold_r != 16'hFFFF)
                hold_r <= hold_r + 16'h0001;
            if (!held || rep_fire)
                rep_r <= 16'h0000;
            else if (tick && hold_r >= HOLD_T)
                rep_r <= rep_r + 16'h0001;
            if (any_btn || !in_cfg)
                idle_r <= 16'h0000;
            else if (tick)
                idle_r <= idle_r + 16'h0001;
        end
    end

    // first order low pass on the committed filter time
    wire [15:0] n_filter_time_menu = cur_r[P_FILTER_TIME_MENU];
    wire signed [16:0] diff_w = $signed({meas_r[15], meas_r}) - $signed({filter_time_menu_y_r[15], filter_time_menu_y_r});
    wire signed [16:0] q_w = diff_w / $signed({1'b0, n_filter_time_menu});
    wire samp = tick & (samp_r == SAMP_T);
    wire [15:0] f_w = (n_filter_time_menu == FILTER_TIME_MENU_MIN) ? meas_r : filter_time_menu_y_r;

    // scaling and range limit decision
    wire signed [15:0] dlo_w = $signed(cur_r[P_DLO]);
    wire signed [15:0] dhi_w = $signed(cur_r[P_DHI]);
    wire signed [16:0] span_w = $signed({dhi_w[15], dhi_w}) - $signed({dlo_w[15], dlo_w});
    wire signed [33:0] prod_w = span_w * $signed({f_w[15], f_w});
    wire signed [33:0] quo_w = prod_w / S_DIV;
    wire [15:0] scaled_w = cur_r[P_DLO] + quo_w[15:0];
    wire f_over = $signed(f_w) > S_OVR;
    wire f_under = $signed(f_w) < S_UND;
    wire f_high = $signed(f_w) > S_HI;
    wire f_low = $signed(f_w) < $signed(16'h0000);
    wire [15:0] lim_w = cur_r[P_LIM];
    wire err_hi = f_over | (lim_w == LIMIT_ERROR_MODE & f_high);
    wire err_lo = f_under | (lim_w == LIMIT_ERROR_MODE & f_low);
    wire clamp = (lim_w == LIMIT_CLAMP_MODE);
    wire [15:0] disp_w = (clamp & f_high) ? cur_r[P_DHI] :
        (clamp & f_low) ? cur_r[P_DLO] : scaled_w;
    wire [1:0] err_w = err_hi ? ERR_HIGH : err_lo ? ERR_LOW : ERR_NONE;

    // register read decode
    wire [31:0] rd_mux = (addr_in == REG_MEAS) ? {16'h0000, meas_r} :
        (addr_in == REG_STATUS) ? {21'h00_0000, in_cfg, edit_r, state_r} :
        (addr_in == REG_CFG) ? {cur_r[P_LIM][3:0], cur_r[P_DP][3:0],
            cur_r[P_SENS][3:0], cur_r[P_TYPE][3:0], 16'h0000} :
        (addr_in == REG_SCALE) ? {cur_r[P_DHI], cur_r[P_DLO]} :
        (addr_in == REG_FILTER_TIME_MENU) ? {16'h0000, cur_r[P_FILTER_TIME_MENU]} :
        (addr_in == REG_DISP) ? {14'h0000, err_w, disp_w} : 32'h0000_0000;

    // measurement write, filter state and bus read
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            meas_r <= 16'h0000;
            filter_time_menu_y_r <= 16'h0000;
            samp_r <= 4'h0;
            rd_data_out <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            if (wr_in && addr_in == REG_MEAS)
                meas_r <= wdata_in[15:0];
            if (tick)
                samp_r <= samp ? 4'h0 : samp_r + 4'h1;
            if (samp)
                filter_time_menu_y_r <= filter_time_menu_y_r + q_w[15:0];
            rd_data_out <= rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    // registered user outputs
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            menu_out <= ST_IDLE;
            editing_out <= 1'b0;
            edit_value_out <= 16'h0000;
            in_config_out <= 1'b0;
            defaults_out <= 1'b0;
            disp_value_out <= 16'h0000;
            disp_err_out <= ERR_NONE;
            disp_dp_out <= 2'h0;
        end
        else if (ce_in)
        begin
            menu_out <= state_nxt;
            editing_out <= edit_nxt;
            edit_value_out <= (sel_w == P_NONE) ? 16'h0000 : sess_r[sel_w];
            in_config_out <= in_cfg;
            defaults_out <= save & dflt_r;
            disp_value_out <= disp_w;
            disp_err_out <= err_w;
            disp_dp_out <= cur_r[P_DP][1:0];
        end
    end

    // checks
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire [15:0] val_w = (sel_w == P_NONE) ? 16'h0000 : sess_r[sel_w];
    wire [15:0] up_w = (sel_w == P_NONE) ? 16'h0000 : up_a[sel_w];
    wire [15:0] dn_w = (sel_w == P_NONE) ? 16'h0000 : dn_a[sel_w];
    wire [15:0] lo_w = (sel_w == P_NONE) ? 16'h0000 : lo_a[sel_w];
    wire [15:0] hi_w = (sel_w == P_NONE) ? 16'h0000 : hi_a[sel_w];

    inact_abort_a: assert property (ce_in && abort |=> state_r == ST_IDLE && !edit_r)
        else $error("inactivity did not abort");
    step_up_a: assert property (ce_in && step_up |=> val_w == $past(up_w))
        else $error("up step wrong");
    step_dn_a: assert property (ce_in && step_dn |=> val_w == $past(dn_w))
        else $error("down step wrong");
    no_early_rep_a: assert property (btn_mid_in && !mp && hold_r < HOLD_T |-> !step_up)
        else $error("repeat before hold time");
    fast_rate_a: assert property (rep_fire && hold_r >= FAST_SET_T |-> rep_r == FAST_P)
        else $error("fast repeat period wrong");
    wrap_up_a: assert property (ce_in && step_up && val_w == hi_w |=> val_w == $past(lo_w))
        else $error("no wrap at top");
    entry_open_a: assert property (ce_in && entry |=> state_r == ST_INP ##1 !step_up)
        else $error("entry failed");
    accept_a: assert property (ce_in && in_cfg && edit_r && lp && !abort
        |=> !edit_r && state_r == $past(state_r))
        else $error("accept did not return to label");
    dflt_a: assert property (ce_in && stepped && sel_w == 3'(P_TYPE)
        |=> sess_r[P_FILTER_TIME_MENU] == DEF_VAL[P_FILTER_TIME_MENU])
        else $error("defaults not restored");
    hard_err_a: assert property (ce_in && f_over |=> disp_err_out == ERR_HIGH)
        else $error("over range not flagged");
    clamp_hi_a: assert property (ce_in && clamp && f_high && !f_over
        |=> disp_value_out == $past(cur_r[P_DHI]) && disp_err_out == ERR_NONE)
        else $error("clamp value wrong");
    entry_c: cover property (ce_in && entry);
    save_c: cover property (ce_in && save);
    abort_c: cover property (ce_in && abort);
    fast_c: cover property (rep_fire && rep_fast && step_up);
endmodule
`default_nettype wire

// ===== verification/icm_operator.sv
// operator model at the three front buttons of the menu
// assumes the bench calls push by hierarchical reference, one press at a time
`timescale 1ns/1ns
`default_nettype none
module icm_operator (
    input wire logic clk_in,
    output logic btn_left_out,
    output logic btn_mid_out,
    output logic btn_right_out
);
    // all buttons released at power up
    initial
    begin
        btn_left_out = 1'b0;
        btn_mid_out = 1'b0;
        btn_right_out = 1'b0;
    end
    // hold one button (0 left, 1 middle, 2 right), then release for a gap
    task automatic push(input int which, input int hold, input int gap);
        @(posedge clk_in);
        btn_left_out <= (which == 0);
        btn_mid_out <= (which == 1);
        btn_right_out <= (which == 2);
        repeat (hold) @(posedge clk_in);
        btn_left_out <= 1'b0;
        btn_mid_out <= 1'b0;
        btn_right_out <= 1'b0;
        repeat (gap) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ===== verification/indicator_config_menu_tb_top.sv
// self-checking bench for the configuration menu
// assumes a shortened tick and inactivity limit, operator model drives buttons
`timescale 1ns/1ns
`default_nettype none
module indicator_config_menu_tb_top;
    import icm_pkg::*;
    localparam int TK = 4;
    localparam int INACT = 50;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sel_done = 1'b0;
    logic ce = 1'b1;
    logic dflt_seen = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rd_data;
    logic [8:0] menu;
    logic editing, in_cfg, dflt;
    logic [15:0] edit_val, disp_val;
    logic [1:0] disp_err, disp_dp;
    wire logic b_l, b_m, b_r;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int i, v0, v1, v2, v3, e, d;
    int meas [4] = '{10500, 20000, -5000, 0};
    logic [31:0] rv;
    logic [8:0] lbl [7] = '{9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100};
    icm_top #(.TICK_CYC_P(TK), .INACT_T_P(INACT)) icm_top_inst (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .ce_in(ce), .btn_left_in(b_l), .btn_mid_in(b_m),
        .btn_right_in(b_r), .selftest_done_in(sel_done), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .menu_out(menu),
        .editing_out(editing), .edit_value_out(edit_val), .in_config_out(in_cfg),
        .defaults_out(dflt), .disp_value_out(disp_val), .disp_err_out(disp_err),
        .disp_dp_out(disp_dp));
    icm_operator icm_operator_inst (.clk_in(core_clk_in), .btn_left_out(b_l),
        .btn_mid_out(b_m), .btn_right_out(b_r));
    // 25 mhz clock
    initial
    begin
        forever #20 core_clk_in = ~core_clk_in;
    end
    // hang guard
    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t timeout", $time);
            tally_and_finish();
        end
    end
    // latch the one-cycle defaults pulse
    always @(posedge core_clk_in)
    begin
        if (dflt)
            dflt_seen <= 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one write cycle
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] dv);
        @(posedge core_clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= dv;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask
    // read strobe, data taken in the following cycle
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] dv);
        @(posedge core_clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1 dv = rd_data;
    endtask
    task automatic tap(input int b);
        icm_operator_inst.push(b, 20 * TK, 20 * TK);
    endtask
    task automatic enter_cfg();
        icm_operator_inst.push(1, (ENTRY_TICKS + 10) * TK, 20 * TK);
        check(menu, 9'h002, "entry label");
    endtask
    task automatic wait_tk(input int n);
        repeat (n * TK) @(posedge core_clk_in);
        #1;
    endtask
    // expected display with default scaling 0..1000 and limit off
    function automatic int exp_disp(input int f);
        return 1000 * f / 10000;
    endfunction
    function automatic logic [1:0] exp_err(input int f);
        return (f > 11000) ? ERR_HIGH : (f < -1000) ? ERR_LOW : ERR_NONE;
    endfunction
    // main sequence
    initial
    begin
        $urandom(32'hd447);
        meas[3] = $urandom_range(0, 10000);
        repeat (3) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        sel_done <= 1'b1;
        #1 check(menu, 9'h001, "reset label");
        check(in_cfg, 1'b0, "reset config");
        bus_rd(8'hFC, rv);
        check(rv, 32'h0000_0000, "unmapped read");
        $display("test reset done");
        // display path across the range, margin and error codes
        foreach (meas[k])
        begin
            bus_wr(REG_MEAS, meas[k]);
            wait_tk(1200);
            e = exp_disp(meas[k]);
            d = $signed(disp_val);
            check(disp_err, exp_err(meas[k]), "error code");
            if (exp_err(meas[k]) == ERR_NONE)
                check(d >= e - 1 && d <= e, 1'b1, "scaled value");
            bus_rd(REG_DISP, rv);
            check(rv[17:16], exp_err(meas[k]), "disp reg error");
        end
        $display("test display done");
        // type cycling, wrap, accept, inactivity abort
        enter_cfg();
        tap(2);
        check(edit_val, 16'h0008, "wrap down");
        for (i = 0; i < 10; i++)
        begin
            tap(1);
            check(edit_val, i % 9, "type step up");
        end
        tap(1);
        check(edit_val, 16'h0001, "single step");
        ce <= 1'b0;
        tap(2);
        ce <= 1'b1;
        check(edit_val, 16'h0001, "frozen by enable");
        tap(0);
        check({editing, menu}, {1'b0, 9'h002}, "accept");
        wait_tk(INACT + 10);
        check(menu, 9'h001, "inactivity abort");
        bus_rd(REG_CFG, rv);
        check(rv[19:16], 4'h0, "session dropped");
        $display("test type menu done");
        // label walk and auto repeat on display low
        enter_cfg();
        for (i = 0; i < 3; i++)
        begin
            if (i == 1)
            begin
                tap(1); // sensor 10 V -> 2 V
                tap(0);
            end
            tap(0);
            check(menu, lbl[i], "label order");
        end
        fork
            icm_operator_inst.push(1, 4000 * TK, 20 * TK);
            begin
                wait_tk(1500);
                v0 = $signed(edit_val);
                wait_tk(400);
                v1 = $signed(edit_val);
                wait_tk(1600);
                v2 = $signed(edit_val);
                wait_tk(400);
                v3 = $signed(edit_val);
            end
        join
        check(v0 > 1 && v1 - v0 >= 1 && v1 - v0 <= 3, 1'b1, "slow repeat");
        check(v3 - v2 >= 8 && v3 - v2 <= 12, 1'b1, "fast repeat");
        tap(0);
        check(menu, 9'h010, "accept low");
        for (i = 3; i < 7; i++)
        begin
            if (i == 5)
            begin
                tap(1); // limit off -> error -> clamp
                tap(1);
                tap(0);
            end
            tap(0);
            check(menu, lbl[i], "label order");
        end
        tap(0);
        check(menu, 9'h001, "save exit");
        wait_tk(2);
        check(in_cfg, 1'b0, "left config");
        check(dflt_seen, 1'b1, "defaults pulse");
        check(disp_dp, 2'h2, "default dp");
        bus_rd(REG_CFG, rv);
        check(rv[23:20], 4'h1, "sensor saved");
        check(rv[31:28], 4'h2, "clamp saved");
        bus_wr(REG_MEAS, 32'h0000_2904);
        wait_tk(600);
        check(disp_val, 16'h03E8, "clamp high value");
        check(disp_err, ERR_NONE, "clamp no error");
        $display("test label walk done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
